// >>> design/mcg_pkg.sv
// Package holding the address map, field positions, reset values and carriers of the glue logic
package mcg_pkg;
  // Controller external data address map
  localparam logic [15:0] ADDR_OUT_PORT = 16'hd000;
  localparam logic [15:0] ADDR_UART_DIV = 16'hd400;
  localparam logic [15:0] ADDR_CTRL_PORT = 16'hd800;
  localparam logic [15:0] ADDR_LINE_STAT = 16'he000;
  localparam logic [15:0] ADDR_DIV_READ = 16'hec00;
  localparam logic [15:0] ADDR_TX_DSP = 16'hf000;
  localparam logic [15:0] ADDR_PNP_DATA = 16'hf800;
  localparam logic [15:0] ADDR_WAKE = 16'hf810;
  // Reset values
  localparam logic [7:0] UART_DIV_RST = 8'h06;
  localparam logic [3:0] OUT_PORT_RST = 4'h0;
  localparam logic [3:0] LINE_STAT_RST = 4'hf;
  localparam logic [7:0] PNP_MEM_RST = 8'h00;
  // Divider limits, in half periods
  localparam logic [5:0] DIV_HALF_MIN = 6'h01;
  localparam logic [5:0] DIV_HALF_MAX = 6'h20;
  // Plug-and-play store depth
  localparam int PNP_DEPTH = 16;
  localparam int PNP_IDX_W = 4;
  // Port 1 bit positions
  localparam int P1_BELL = 0;
  localparam int P1_DTR = 1;
  localparam int P1_HOOK = 2;
  localparam int P1_BANK_LO = 3;
  localparam int P1_EE = 4;
  localparam int P1_BANK_HI = 7;
  // Special register bit positions
  localparam int SLEEP_BIT_POS = 1;
  localparam int SFR_UPPER = 1;
  localparam int SFR_SWAP = 2;
  // Controller external data bus
  typedef struct packed {
    logic [15:0] addr;
    logic rd_n;
    logic wr_n;
    logic [7:0] wdata;
  } mcg_bus_t;
  // Line interface output port fields
  typedef struct packed {
    logic voice_relay_n;
    logic speech_path_sel2;
    logic speech_path_sel1;
    logic dsp_reset_n;
  } mcg_outport_t;
  // Pins that cross into the core clock
  typedef struct packed {
    logic [2:0] ee;
    logic rx_baud;
    logic tx_baud;
    logic dtr_n;
    logic bell_n;
    logic autocfg_n;
    logic mode;
  } mcg_pins_t;
endpackage

// >>> design/mcg_glue.sv
// Glue logic around the embedded controller: modes, banks, sleep, registers and selects
// How it works
// - Mode pin low internal, high external
// - Two bank outputs reach 256K program space
// - Each bank is one 64K window
// - Port bits 1.3 and 1.7 choose bank
// - Bank outputs are inverted port bits
// - Sleep bit halts the controller
// - Reset, ring fall or wake write wakes
// - Special bit 1 picks upper direct bank
// - Special bit 2 swaps program and data
// - UART clock by integer division
// - Even divider 2..64, resets to 06
// - Read back low baud divisor byte
// - Write-only line status, low nibble used
// - Output port drives reset, voice, relay
// - PnP bytes stored at successive locations
// - Grounded enable plus key enters PnP
// - Selects for F000 and D800 accesses
// - Address latch and fetch strobe outputs
// - Baud clocks feed interrupts 0 and 1
// - Ready, hook relay, EEPROM on port 1
`timescale 1ns/1ps
`default_nettype none
module mcg_glue (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET,
  // Controller side
  input wire mcg_pkg::mcg_bus_t CORE_BUS,
  input wire logic [7:0] CORE_P1_OUT,
  input wire logic [7:0] CORE_PWR_CTRL,
  input wire logic [7:0] CORE_SFR_8F,
  input wire logic CORE_ALE,
  input wire logic CORE_FETCH_STROBE_N,
  input wire logic [15:0] CORE_PC,
  input wire logic INIT_KEY_SEEN,
  input wire logic [7:0] DIVISOR_LATCH_LOW,
  input wire logic [3:0] PNP_RD_INDEX,
  output logic [7:0] CORE_RDATA,
  output logic CORE_RDATA_OE,
  output logic [7:0] CORE_P1_IN,
  output logic CORE_INT0,
  output logic CORE_INT1,
  output logic CORE_HALT,
  output logic IRAM_UPPER_BANK,
  output logic SWAP_PROG_DATA,
  output logic MODE_EXTERNAL,
  output logic PNP_MODE,
  output logic [3:0] LINE_STATUS_N,
  output logic UART_CLK,
  output logic [7:0] PNP_RD_DATA,
  // Pins in
  input wire logic HOST_OR_STANDALONE_SEL,
  input wire logic BELL_DETECT_N,
  input wire logic AUTOCONFIG_ENABLE_N,
  input wire logic TERMINAL_READY_N,
  input wire logic TX_BAUD_CLOCK_IN,
  input wire logic RX_BAUD_CLOCK_IN,
  input wire logic [2:0] EEPROM_IN,
  // Pins out
  output logic BANK_SEL_LOW,
  output logic BANK_SEL_HIGH,
  output logic [17:0] EXT_PROG_ADDR,
  output logic HOOK_RELAY_N,
  output logic [2:0] EEPROM_OUT,
  output logic [2:0] EEPROM_OE,
  output logic DSP_RESET_N,
  output logic SPEECH_PATH_SEL1,
  output logic SPEECH_PATH_SEL2,
  output logic VOICE_RELAY_N,
  output logic TX_DSP_SELECT_N,
  output logic CONTROL_PORT_SELECT,
  output logic ADDR_LATCH,
  output logic PROGRAM_FETCH_STROBE_N
);
  mcg_pkg::mcg_pins_t pins_raw, sync1, sync2;
  mcg_pkg::mcg_outport_t outport, next_outport;
  logic wr_n_q, bell_q, sleep_q;
  logic asleep, next_asleep;
  logic [7:0] div_reg, next_div_reg;
  logic [5:0] div_cnt, next_div_cnt, div_half;
  logic uart_clk, next_uart_clk;
  logic [3:0] line_stat, next_line_stat;
  logic [7:0] rdata, next_rdata;
  logic rdata_oe, next_rdata_oe;
  logic [mcg_pkg::PNP_IDX_W-1:0] pnp_ptr, next_pnp_ptr;
  logic [7:0] pnp_mem [mcg_pkg::PNP_DEPTH];
  logic [7:0] next_pnp_mem [mcg_pkg::PNP_DEPTH];
  logic pnp_mode, next_pnp_mode;
  logic wr_take, rd_act, bell_fall, sleep_rise, wake_wr;

  // Pins gathered for the two-stage synchroniser
  assign pins_raw = '{ee: EEPROM_IN, rx_baud: RX_BAUD_CLOCK_IN, tx_baud: TX_BAUD_CLOCK_IN,
                      dtr_n: TERMINAL_READY_N, bell_n: BELL_DETECT_N,
                      autocfg_n: AUTOCONFIG_ENABLE_N, mode: HOST_OR_STANDALONE_SEL};

  // Pin synchroniser; the first stage feeds only the second
  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      sync1 <= '{ee: 3'h7, rx_baud: 1'b0, tx_baud: 1'b0, dtr_n: 1'b1, bell_n: 1'b1,
                 autocfg_n: 1'b1, mode: 1'b0};
      sync2 <= '{ee: 3'h7, rx_baud: 1'b0, tx_baud: 1'b0, dtr_n: 1'b1, bell_n: 1'b1,
                 autocfg_n: 1'b1, mode: 1'b0};
    end
    else
    begin
      sync1 <= pins_raw;
      sync2 <= sync1;
    end
  end

  // Strobe edges; a write is taken once, on the falling write strobe
  assign wr_take = !CORE_BUS.wr_n && wr_n_q;
  assign rd_act = !CORE_BUS.rd_n;
  assign bell_fall = bell_q && !sync2.bell_n;
  assign sleep_rise = CORE_PWR_CTRL[mcg_pkg::SLEEP_BIT_POS] && !sleep_q;
  assign wake_wr = wr_take && CORE_BUS.addr == mcg_pkg::ADDR_WAKE;

  // Half period of the UART clock, clamped so zero or oversized writes stay safe
  always_comb
  begin
    div_half = div_reg[6:1];
    if (div_half < mcg_pkg::DIV_HALF_MIN)
      div_half = mcg_pkg::DIV_HALF_MIN;
    else if (div_half > mcg_pkg::DIV_HALF_MAX)
      div_half = mcg_pkg::DIV_HALF_MAX;
  end

  // Next values of the register file, sleep state, divider and PnP store
  always_comb
  begin
    next_outport = outport;
    next_div_reg = div_reg;
    next_line_stat = line_stat;
    next_pnp_ptr = pnp_ptr;
    next_pnp_mem = pnp_mem;
    next_rdata = 8'h00;
    next_rdata_oe = 1'b0;
    // Writes to read-only or unmapped locations are dropped
    if (wr_take)
    begin
      if (CORE_BUS.addr == mcg_pkg::ADDR_OUT_PORT)
        next_outport = CORE_BUS.wdata[3:0];
      else if (CORE_BUS.addr == mcg_pkg::ADDR_UART_DIV)
        next_div_reg = {1'b0, CORE_BUS.wdata[6:1], 1'b0};
      else if (CORE_BUS.addr == mcg_pkg::ADDR_LINE_STAT)
        next_line_stat = CORE_BUS.wdata[3:0];
      else if (CORE_BUS.addr == mcg_pkg::ADDR_PNP_DATA)
      begin
        next_pnp_mem[pnp_ptr] = CORE_BUS.wdata;
        next_pnp_ptr = pnp_ptr + 1'b1;
      end
    end
    // Only the divisor readback answers a read
    if (rd_act && CORE_BUS.addr == mcg_pkg::ADDR_DIV_READ)
    begin
      next_rdata = DIVISOR_LATCH_LOW;
      next_rdata_oe = 1'b1;
    end
    // Wake counts only once asleep, so a ring in the entry cycle is lost
    if (asleep)
      next_asleep = !(bell_fall || wake_wr);
    else
      next_asleep = sleep_rise;
    // Integer division of the core clock down to the UART rate
    if (div_cnt >= div_half - 6'h01)
    begin
      next_div_cnt = 6'h00;
      next_uart_clk = !uart_clk;
    end
    else
    begin
      next_div_cnt = div_cnt + 6'h01;
      next_uart_clk = uart_clk;
    end
    // Open enable pin forces PnP off, grounded pin waits for the key
    if (sync2.autocfg_n)
      next_pnp_mode = 1'b0;
    else
      next_pnp_mode = pnp_mode || INIT_KEY_SEEN;
  end

  // State registers
  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      wr_n_q <= 1'b1;
      bell_q <= 1'b1;
      sleep_q <= 1'b0;
      asleep <= 1'b0;
      outport <= mcg_pkg::OUT_PORT_RST;
      div_reg <= mcg_pkg::UART_DIV_RST;
      div_cnt <= 6'h00;
      uart_clk <= 1'b0;
      line_stat <= mcg_pkg::LINE_STAT_RST;
      rdata <= 8'h00;
      rdata_oe <= 1'b0;
      pnp_ptr <= '0;
      pnp_mode <= 1'b0;
      for (int i = 0; i < mcg_pkg::PNP_DEPTH; i++)
        pnp_mem[i] <= mcg_pkg::PNP_MEM_RST;
    end
    else
    begin
      wr_n_q <= CORE_BUS.wr_n;
      bell_q <= sync2.bell_n;
      sleep_q <= CORE_PWR_CTRL[mcg_pkg::SLEEP_BIT_POS];
      asleep <= next_asleep;
      outport <= next_outport;
      div_reg <= next_div_reg;
      div_cnt <= next_div_cnt;
      uart_clk <= next_uart_clk;
      line_stat <= next_line_stat;
      rdata <= next_rdata;
      rdata_oe <= next_rdata_oe;
      pnp_ptr <= next_pnp_ptr;
      pnp_mode <= next_pnp_mode;
      pnp_mem <= next_pnp_mem;
    end
  end

  // Output flops for pins and controller side; one cycle behind controller inputs and the second synchroniser stage
  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      BANK_SEL_LOW <= 1'b0;
      BANK_SEL_HIGH <= 1'b0;
      EXT_PROG_ADDR <= 18'h00000;
      HOOK_RELAY_N <= 1'b1;
      EEPROM_OUT <= 3'h0;
      EEPROM_OE <= 3'h0;
      TX_DSP_SELECT_N <= 1'b1;
      CONTROL_PORT_SELECT <= 1'b0;
      ADDR_LATCH <= 1'b0;
      PROGRAM_FETCH_STROBE_N <= 1'b1;
      CORE_P1_IN <= 8'hff;
      CORE_INT0 <= 1'b0;
      CORE_INT1 <= 1'b0;
      IRAM_UPPER_BANK <= 1'b0;
      SWAP_PROG_DATA <= 1'b0;
      MODE_EXTERNAL <= 1'b0;
      PNP_RD_DATA <= 8'h00;
    end
    else
    begin
      // Bank outputs are the inverted port bits, so all ones means bank 0
      BANK_SEL_LOW <= !CORE_P1_OUT[mcg_pkg::P1_BANK_LO];
      BANK_SEL_HIGH <= !CORE_P1_OUT[mcg_pkg::P1_BANK_HI];
      EXT_PROG_ADDR <= {!CORE_P1_OUT[mcg_pkg::P1_BANK_HI], !CORE_P1_OUT[mcg_pkg::P1_BANK_LO],
                        CORE_PC};
      HOOK_RELAY_N <= CORE_P1_OUT[mcg_pkg::P1_HOOK];
      // EEPROM lines are quasi-bidirectional: driven only while low
      EEPROM_OUT <= 3'h0;
      EEPROM_OE <= ~CORE_P1_OUT[mcg_pkg::P1_EE+:3];
      TX_DSP_SELECT_N <= !((rd_act || !CORE_BUS.wr_n) && CORE_BUS.addr == mcg_pkg::ADDR_TX_DSP);
      CONTROL_PORT_SELECT <= (rd_act || !CORE_BUS.wr_n) && CORE_BUS.addr == mcg_pkg::ADDR_CTRL_PORT;
      ADDR_LATCH <= CORE_ALE;
      PROGRAM_FETCH_STROBE_N <= CORE_FETCH_STROBE_N;
      CORE_P1_IN <= {CORE_P1_OUT[7], sync2.ee & CORE_P1_OUT[6:4], CORE_P1_OUT[3:2],
                     sync2.dtr_n, sync2.bell_n};
      CORE_INT0 <= sync2.tx_baud;
      CORE_INT1 <= sync2.rx_baud;
      IRAM_UPPER_BANK <= CORE_SFR_8F[mcg_pkg::SFR_UPPER];
      SWAP_PROG_DATA <= CORE_SFR_8F[mcg_pkg::SFR_SWAP];
      MODE_EXTERNAL <= sync2.mode;
      PNP_RD_DATA <= pnp_mem[PNP_RD_INDEX];
    end
  end

  // Register-backed outputs
  assign CORE_RDATA = rdata;
  assign CORE_RDATA_OE = rdata_oe;
  assign CORE_HALT = asleep;
  assign PNP_MODE = pnp_mode;
  assign LINE_STATUS_N = line_stat;
  assign UART_CLK = uart_clk;
  assign DSP_RESET_N = outport.dsp_reset_n;
  assign SPEECH_PATH_SEL1 = outport.speech_path_sel1;
  assign SPEECH_PATH_SEL2 = outport.speech_path_sel2;
  assign VOICE_RELAY_N = outport.voice_relay_n;

  // Checks beside the logic
  bank_map_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (CORE_P1_OUT[mcg_pkg::P1_BANK_HI] && CORE_P1_OUT[mcg_pkg::P1_BANK_LO])
      |=> (!BANK_SEL_LOW && !BANK_SEL_HIGH && EXT_PROG_ADDR[17:16] == 2'h0))
    else $error("bank 0 not selected");
  mode_pin_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    HOST_OR_STANDALONE_SEL [*3] |=> MODE_EXTERNAL)
    else $error("external mode not reached");
  sleep_entry_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    ($rose(CORE_PWR_CTRL[1]) && !CORE_HALT && !wake_wr) |=> ##1 CORE_HALT)
    else $error("sleep not entered");
  wake_write_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (CORE_HALT && wake_wr) |=> !CORE_HALT)
    else $error("wake write ignored");
  div_write_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (wr_take && CORE_BUS.addr == 16'hd400) |=> (div_reg == {1'b0, $past(CORE_BUS.wdata[6:1]), 1'b0}))
    else $error("divider write lost");
  readback_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (!CORE_BUS.rd_n && CORE_BUS.addr == 16'hec00) |=> (CORE_RDATA_OE && CORE_RDATA == $past(DIVISOR_LATCH_LOW)))
    else $error("divisor readback wrong");
  out_port_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (wr_take && CORE_BUS.addr == 16'hd000) |=> ##1 (DSP_RESET_N == $past(CORE_BUS.wdata[0], 2)
      && VOICE_RELAY_N == $past(CORE_BUS.wdata[3], 2)))
    else $error("output port not driven");
  line_stat_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (wr_take && CORE_BUS.addr == 16'he000) |=> (LINE_STATUS_N == $past(CORE_BUS.wdata[3:0])))
    else $error("line status not taken");
  pnp_step_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (wr_take && CORE_BUS.addr == 16'hf800) |=> (pnp_ptr == $past(pnp_ptr) + 4'h1))
    else $error("pnp pointer stuck");
  tx_select_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (!CORE_BUS.rd_n && CORE_BUS.addr == 16'hf000) |=> !TX_DSP_SELECT_N)
    else $error("tx dsp select missing");
  sleep_cycle_c: cover property (@(posedge CORE_CLK) disable iff (RESET) CORE_HALT ##[1:50] !CORE_HALT);
  bank_three_c: cover property (@(posedge CORE_CLK) disable iff (RESET) BANK_SEL_LOW && BANK_SEL_HIGH);
  pnp_enter_c: cover property (@(posedge CORE_CLK) disable iff (RESET) $rose(PNP_MODE));
  uart_tick_c: cover property (@(posedge CORE_CLK) disable iff (RESET) $rose(UART_CLK));
endmodule
`default_nettype wire

// >>> tb/mcg_core_model.sv
// Behavioural controller core: drives the external data bus and the port 1 latch
`timescale 1ns/1ps
`default_nettype none
module mcg_core_model (
  // Clock
  input wire logic clk,
  // Core outputs
  output var mcg_pkg::mcg_bus_t bus,
  output var logic [7:0] p1
);
  // Idle bus, port latch at its reset level
  initial bus = '{16'h0000, 1'b1, 1'b1, 8'h00};
  initial p1 = 8'hff;

  // Write strobe low for one edge, then high for one edge so the next fall is seen
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    bus = '{a, 1'b1, 1'b0, d};
    @(negedge clk);
    bus.wr_n = 1'b1;
    bus.wdata = ~d; // Released data no longer shows the last byte
    @(negedge clk);
  endtask

  // Read stays asserted on return so the caller can look at the answer
  task automatic rd(input logic [15:0] a);
    @(negedge clk);
    bus = '{a, 1'b0, 1'b1, 8'h00};
    @(negedge clk);
  endtask

  task automatic idle();
    bus.rd_n = 1'b1;
    @(negedge clk);
  endtask

  task automatic port(input logic [7:0] v);
    @(negedge clk);
    p1 = v;
  endtask

  // Bank choice on bits 3 and 7, software jumps afterwards
  task automatic bank(input logic [1:0] b);
    @(negedge clk);
    p1[3] = ~b[0];
    p1[7] = ~b[1];
  endtask
endmodule
`default_nettype wire

// >>> tb/test_modem_controller_glue_logic.sv
// Self-checking bench of the controller glue logic
`timescale 1ns/1ps
`default_nettype none
module test_modem_controller_glue_logic;
  typedef struct { string n; logic [31:0] v; } mcg_note_t;
  logic clk = 1'b0, rst = 1'b1;
  logic [7:0] pwr = 8'h00, sfr = 8'h00, dll = 8'h00;
  logic ale = 1'b0, fetch_n = 1'b1, key = 1'b0, sel = 1'b0, bell_n = 1'b1;
  logic pnp_n = 1'b1, dtr_n = 1'b1, txb = 1'b0, rxb = 1'b0;
  logic [15:0] pc = 16'h0000;
  logic [3:0] idx = 4'h0;
  logic [2:0] ee_drv = 3'h7;
  mcg_pkg::mcg_bus_t bus;
  logic [7:0] p1, rdata, p1_in, pdat;
  logic oe, int0, int1, halt, upper, swap, mode, pnp, uclk;
  logic bsl, bsh, hook, dsp_n, s1, s2, vr_n, tx_n, cps, alo, psno;
  logic [3:0] stat;
  logic [17:0] epa;
  logic [2:0] ee_out, ee_oe;
  // Open-drain wire: pulled up, low while the design enables its driver
  wire logic [2:0] ee_in = ee_drv & ~ee_oe;
  mcg_note_t q[$];
  event chk_ev;
  int err_total = 0, num_checks = 0, seed = 27983;
  int hv [4] = '{3, 1, 2, 32};
  logic [7:0] dv [4] = '{8'h06, 8'h02, 8'h04, 8'hc1};
  logic [15:0] ra [4] = '{16'hec00, 16'hf000, 16'hd800, 16'h1234};

  mcg_core_model i_mcg_core_model (.clk(clk), .bus(bus), .p1(p1));
  mcg_glue i_mcg_glue (
    .CORE_CLK(clk), .RESET(rst), .CORE_BUS(bus), .CORE_P1_OUT(p1), .CORE_PWR_CTRL(pwr),
    .CORE_SFR_8F(sfr), .CORE_ALE(ale), .CORE_FETCH_STROBE_N(fetch_n), .CORE_PC(pc), .INIT_KEY_SEEN(key),
    .DIVISOR_LATCH_LOW(dll), .PNP_RD_INDEX(idx), .CORE_RDATA(rdata), .CORE_RDATA_OE(oe),
    .CORE_P1_IN(p1_in), .CORE_INT0(int0), .CORE_INT1(int1), .CORE_HALT(halt), .IRAM_UPPER_BANK(upper),
    .SWAP_PROG_DATA(swap), .MODE_EXTERNAL(mode), .PNP_MODE(pnp), .LINE_STATUS_N(stat), .UART_CLK(uclk),
    .PNP_RD_DATA(pdat), .HOST_OR_STANDALONE_SEL(sel), .BELL_DETECT_N(bell_n),
    .AUTOCONFIG_ENABLE_N(pnp_n), .TERMINAL_READY_N(dtr_n), .TX_BAUD_CLOCK_IN(txb),
    .RX_BAUD_CLOCK_IN(rxb), .EEPROM_IN(ee_in), .BANK_SEL_LOW(bsl), .BANK_SEL_HIGH(bsh),
    .EXT_PROG_ADDR(epa), .HOOK_RELAY_N(hook), .EEPROM_OUT(ee_out), .EEPROM_OE(ee_oe),
    .DSP_RESET_N(dsp_n), .SPEECH_PATH_SEL1(s1), .SPEECH_PATH_SEL2(s2), .VOICE_RELAY_N(vr_n),
    .TX_DSP_SELECT_N(tx_n), .CONTROL_PORT_SELECT(cps), .ADDR_LATCH(alo), .PROGRAM_FETCH_STROBE_N(psno)
  );

  // 40 MHz core clock
  initial forever #12.5 clk = ~clk;

  task automatic note(input string n, input logic [31:0] v);
    q.push_back('{n, v});
    ->chk_ev;
  endtask

  // Groups of outputs, looked up by the name carried in a note
  function automatic logic [31:0] obs(input string n);
    case (n)
      "port": return {vr_n, s2, s1, dsp_n};
      "stat": return stat;
      "rd": return {oe, rdata};
      "sel": return {tx_n, cps};
      "bank": return {bsh, bsl, epa};
      "halt": return halt;
      "uclk": return uclk;
      "mode": return mode;
      "sfr": return {swap, upper};
      "strb": return {alo, psno};
      "pins": return {int1, int0, p1_in, hook, ee_oe, ee_out};
      "pdat": return pdat;
      "pnp": return pnp;
      default: return 32'hffffffff;
    endcase
  endfunction

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic end_sim();
    #1;
    if (err_total == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Bounded wait for the divided clock to change level
  task automatic wait_uclk();
    logic v;
    int n;
    v = uclk;
    n = 0;
    while (uclk === v && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 100)
    begin
      err_total++;
      end_sim();
    end
  endtask

  // Checker process: takes all queued notes, oldest first, whenever a result is flagged
  initial forever
  begin
    @(chk_ev);
    while (q.size() > 0)
    begin
      mcg_note_t e;
      e = q.pop_front();
      cmp(e.n, e.v, obs(e.n));
    end
  end

  // Watchdog against a hung run
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    end_sim();
  end

  initial
  begin
    logic [7:0] r;
    logic [7:0] mem [16];
    logic v;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    note("stat", 4'hf);
    note("port", 4'h0);
    note("sel", 2'b10);
    // Divider: reset value first, then minimum, plain and maximum with stray bits 7 and 0
    foreach (hv[i])
    begin
      if (i > 0)
        i_mcg_core_model.wr(mcg_pkg::ADDR_UART_DIV, dv[i]);
      repeat (2) wait_uclk();
      v = uclk;
      repeat (hv[i] - 1) @(negedge clk);
      note("uclk", v);
      @(negedge clk);
      note("uclk", {~v});
    end
    // All four program banks
    for (int i = 0; i < 4; i++)
    begin
      i_mcg_core_model.bank(i[1:0]);
      pc = 16'($random(seed));
      @(negedge clk);
      note("bank", {i[1:0], i[1:0], pc});
    end
    // Write-only registers, upper nibbles ignored
    repeat (4)
    begin
      r = 8'($random(seed));
      i_mcg_core_model.wr(mcg_pkg::ADDR_OUT_PORT, r);
      note("port", r[3:0]);
      i_mcg_core_model.wr(mcg_pkg::ADDR_LINE_STAT, ~r);
      note("stat", {~r[3:0]});
    end
    // Reads and selects; writes to read-only or unmapped places leave the port alone
    foreach (ra[i])
    begin
      dll = 8'($random(seed));
      i_mcg_core_model.wr(ra[i], ~dll);
      i_mcg_core_model.rd(ra[i]);
      note("rd", {ra[i] == mcg_pkg::ADDR_DIV_READ, (ra[i] == mcg_pkg::ADDR_DIV_READ) ? dll : 8'h00});
      note("sel", {ra[i] != mcg_pkg::ADDR_TX_DSP, ra[i] == mcg_pkg::ADDR_CTRL_PORT});
      i_mcg_core_model.idle();
      note("port", r[3:0]);
    end
    // Sleep, wake by register write, no re-entry while the bit stays high, wake by ring fall
    pwr[1] = 1'b1;
    repeat (3) @(negedge clk);
    note("halt", 1'b1);
    i_mcg_core_model.wr(mcg_pkg::ADDR_WAKE, r);
    note("halt", 1'b0);
    repeat (4) @(negedge clk);
    note("halt", 1'b0);
    pwr[1] = 1'b0;
    @(negedge clk);
    pwr[1] = 1'b1;
    repeat (3) @(negedge clk);
    note("halt", 1'b1);
    bell_n = 1'b0;
    repeat (5) @(negedge clk);
    note("halt", 1'b0);
    bell_n = 1'b1;
    pwr[1] = 1'b0;
    @(negedge clk);
    pwr[1] = 1'b1;
    repeat (3) @(negedge clk);
    // Reset pulse in mid-run also wakes and restores the registers
    rst = 1'b1;
    @(negedge clk);
    note("halt", 1'b0);
    note("stat", 4'hf);
    pwr[1] = 1'b0;
    rst = 1'b0;
    repeat (2) @(negedge clk);
    // Pins, port 1, special bits and strobes with random levels
    repeat (4)
    begin
      r = 8'($random(seed));
      {txb, rxb, dtr_n, ale, fetch_n, sel} = r[5:0];
      ee_drv = r[7:5];
      sfr = r;
      i_mcg_core_model.port(~r);
      repeat (4) @(negedge clk);
      note("mode", sel);
      note("sfr", r[2:1]);
      note("strb", {ale, fetch_n});
      note("pins", {rxb, txb, p1[7], ee_drv & p1[6:4], p1[3:2], dtr_n, bell_n, p1[2], ~p1[6:4], 3'h0});
    end
    // Seventeen data bytes: the last one wraps onto the first place
    for (int i = 0; i < 17; i++)
    begin
      r = 8'($random(seed));
      mem[i % 16] = r;
      i_mcg_core_model.wr(mcg_pkg::ADDR_PNP_DATA, r);
    end
    for (int i = 0; i < 16; i++)
    begin
      idx = i[3:0];
      repeat (2) @(negedge clk);
      note("pdat", mem[i]);
    end
    // Key is refused while the enable pin floats high, taken when it is grounded
    for (int i = 0; i < 2; i++)
    begin
      pnp_n = (i == 0);
      repeat (4) @(negedge clk);
      key = 1'b1;
      @(negedge clk);
      key = 1'b0;
      repeat (2) @(negedge clk);
      note("pnp", i);
    end
    pnp_n = 1'b1;
    repeat (4) @(negedge clk);
    note("pnp", 1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
